// ===== verilog/dblc_defs.svh
// Constants for the double-buffered converter latch controller.
`ifndef DBLC_DEFS_SVH
`define DBLC_DEFS_SVH
// Minimum qualified write strobe low time in ns.
`define DBLC_STROBE_MIN_NS 900
// Minimum data hold time after the strobe rises, in ns.
`define DBLC_HOLD_MIN_NS 50
// System clock period in ns.
`define DBLC_CLK_PERIOD_NS 50
// Strobe low cycles, rounded up.
`define DBLC_STROBE_CYC ((`DBLC_STROBE_MIN_NS + `DBLC_CLK_PERIOD_NS - 1) / `DBLC_CLK_PERIOD_NS)
// Hold cycles, rounded up, at least one.
`define DBLC_HOLD_CYC ((`DBLC_HOLD_MIN_NS + `DBLC_CLK_PERIOD_NS - 1) / `DBLC_CLK_PERIOD_NS)
// Data width of the converter code.
`define DBLC_DATA_W 8
// Reset value of the data pins.
`define DBLC_DATA_RST 8'h00
`endif

// ===== verilog/dblc_pkg.sv
// Types shared by the double-buffered converter latch controller.
`include "dblc_defs.svh"
package dblc_pkg;
	// Command codes requested on the user port.
	typedef enum logic [1:0] {
		DBLC_CMD_LOAD  = 2'b00,
		DBLC_CMD_TRANSFER_SELECT_N  = 2'b01,
		DBLC_CMD_WRITE = 2'b10,
		DBLC_CMD_FLOW  = 2'b11
	} dblc_cmd_t;
	// Sequencer states.
	typedef enum logic [2:0] {
		DBLC_ST_IDLE  = 3'b000,
		DBLC_ST_SETUP = 3'b001,
		DBLC_ST_PULSE = 3'b010,
		DBLC_ST_HOLD  = 3'b011,
		DBLC_ST_FLOW  = 3'b100
	} dblc_state_t;
	// Pin group driven toward the converter.
	typedef struct packed {
		logic       input_latch_qualifier;
		logic       chip_select_n;
		logic       input_write_strobe_n;
		logic       transfer_write_strobe_n;
		logic       transfer_select_n;
		logic [7:0] data_in_bits;
	} dblc_pins_t;
endpackage

// ===== verilog/dblc_cnt.sv
// Down counter that times strobe and hold phases.
`timescale 1ns/1ns
module dblc_cnt
	import dblc_pkg::*;
#(
	parameter int W = 6
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] value_i,
	output logic              done_o
);
	logic [W-1:0] cnt_ff;  // Remaining cycles.
	logic [W-1:0] nxt_cnt; // Next remaining cycles.

	// A load sets the count; otherwise it falls to zero and stays there.
	always_comb begin
		nxt_cnt = cnt_ff;
		if (load_i) begin
			nxt_cnt = value_i;
		end else if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - W'(1);
		end
	end

	// Register the count; reset leaves it expired.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// Done is high on the last loaded cycle (count one) and once the count has run out.
	assign done_o = (cnt_ff == W'(1)) || (cnt_ff == '0);
endmodule // dblc_cnt

// ===== verilog/dblc_host.sv
// Controller that drives the latch pins of a double-buffered 8-bit converter.
`timescale 1ns/1ns
`include "dblc_defs.svh"

// Functional notes
// - Double buffer: select low, pulse input strobe.
// - Single buffer pulses only input strobe.
// - Hold each strobe low at least 900 ns.
// - Keep data 50 ns after strobe rises.
// - Data latched on strobe rising edge.
// - Stretch strobe and hold in wait states.
// - Single buffer latches in input register.
// - Qualifier tied high when freeze unused.
module dblc_host
	import dblc_pkg::*;
#(
	parameter int DATA_W    = `DBLC_DATA_W,
	parameter int STROBE_CY = `DBLC_STROBE_CYC,
	parameter int HOLD_CY   = `DBLC_HOLD_CYC
) (
	input  wire logic              CLK_SYS_I,
	input  wire logic              RST_N_I,
	input  wire logic              REQ_VALID_I,
	input  wire dblc_cmd_t         REQ_CMD_I,
	input  wire logic [DATA_W-1:0] REQ_DATA_I,
	input  wire logic              FREEZE_I,
	output logic                   REQ_READY_O,
	output logic                   DONE_O,
	output logic                   INPUT_LATCH_QUALIFIER_O,
	output logic                   CHIP_SELECT_N_O,
	output logic                   INPUT_WRITE_STROBE_N_O,
	output logic                   TRANSFER_WRITE_STROBE_N_O,
	output logic                   TRANSFER_SELECT_N_O,
	output logic [DATA_W-1:0]      DATA_IN_BITS_O
);
	localparam int CW = 6; // Counter width, enough for the strobe figure.

	dblc_state_t       state_ff;    // Sequencer state.
	dblc_state_t       nxt_state;   // Next sequencer state.
	dblc_cmd_t         cmd_ff;      // Command in progress.
	dblc_cmd_t         nxt_cmd;     // Next command in progress.
	dblc_pins_t        pins_ff;     // Registered pin drive.
	dblc_pins_t        nxt_pins;    // Next pin drive.
	logic              done_ff;     // Completion pulse.
	logic              nxt_done;    // Next completion pulse.
	logic              frz_ff;      // Freeze request, registered.
	logic              cnt_load;    // Reload for the phase counter.
	logic [CW-1:0]     cnt_value;   // Value loaded into the counter.
	logic              cnt_done;    // Current phase has run out.

	// Phase timer for strobe width and hold time.
	dblc_cnt #(
		.W (CW)
	) u_cnt (
		.clk_i   (CLK_SYS_I),
		.rst_n_i (RST_N_I),
		.load_i  (cnt_load),
		.value_i (cnt_value),
		.done_o  (cnt_done)
	);

	// Ready only when idle or flowing, so requests never overlap a strobe.
	assign REQ_READY_O = (state_ff == DBLC_ST_IDLE) || (state_ff == DBLC_ST_FLOW);

	// Sequencer: setup, strobe low, strobe high with data held, then idle.
	always_comb begin
		nxt_state = state_ff;
		nxt_cmd   = cmd_ff;
		nxt_pins  = pins_ff;
		nxt_done  = 1'b0;
		cnt_load  = 1'b0;
		cnt_value = '0;
		// The qualifier follows the freeze input; high whenever freeze is unused.
		nxt_pins.input_latch_qualifier = ~frz_ff;
		case (state_ff)
			DBLC_ST_IDLE, DBLC_ST_FLOW: begin
				if (REQ_VALID_I) begin
					nxt_cmd = REQ_CMD_I;
					// Data goes out before the pulsed strobe falls; write and flow drop their other strobes with it, bit 0 as LSB.
					nxt_pins.data_in_bits = REQ_DATA_I;
					nxt_pins.input_write_strobe_n    = 1'b1;
					nxt_pins.transfer_write_strobe_n = 1'b1;
					nxt_pins.transfer_select_n       = 1'b1;
					nxt_pins.chip_select_n           = 1'b1;
					case (REQ_CMD_I)
						DBLC_CMD_LOAD: begin
							// Select gates the input latch only.
							nxt_pins.chip_select_n = 1'b0;
						end
						DBLC_CMD_TRANSFER_SELECT_N: begin
							// Transfer gates only the converter latch.
							nxt_pins.transfer_select_n = 1'b0;
						end
						DBLC_CMD_WRITE: begin
							// Converter register held open; input register latches.
							nxt_pins.chip_select_n           = 1'b0;
							nxt_pins.transfer_write_strobe_n = 1'b0;
							nxt_pins.transfer_select_n       = 1'b0;
						end
						default: begin
							// Flow through: every line low makes both latches transparent.
							nxt_pins.chip_select_n           = 1'b0;
							nxt_pins.input_write_strobe_n    = 1'b0;
							nxt_pins.transfer_write_strobe_n = 1'b0;
							nxt_pins.transfer_select_n       = 1'b0;
						end
					endcase
					if (REQ_CMD_I == DBLC_CMD_FLOW) begin
						nxt_state = DBLC_ST_FLOW;
						nxt_done  = 1'b1;
					end else begin
						nxt_state = DBLC_ST_SETUP;
					end
				end else if (state_ff == DBLC_ST_FLOW) begin
					// Output keeps following the data pins until another command.
					nxt_state = DBLC_ST_FLOW;
				end
			end
			DBLC_ST_SETUP: begin
				// Strobe falls one cycle after data and selects settle.
				if (cmd_ff == DBLC_CMD_TRANSFER_SELECT_N) begin
					nxt_pins.transfer_write_strobe_n = 1'b0;
				end else begin
					nxt_pins.input_write_strobe_n = 1'b0;
				end
				cnt_load  = 1'b1;
				cnt_value = CW'(STROBE_CY);
				nxt_state = DBLC_ST_PULSE;
			end
			DBLC_ST_PULSE: begin
				// Strobe stays low for the full minimum width.
				if (cnt_done) begin
					if (cmd_ff == DBLC_CMD_TRANSFER_SELECT_N) begin
						nxt_pins.transfer_write_strobe_n = 1'b1;
					end else begin
						nxt_pins.input_write_strobe_n = 1'b1;
					end
					cnt_load  = 1'b1;
					cnt_value = CW'(HOLD_CY);
					nxt_state = DBLC_ST_HOLD;
				end
			end
			DBLC_ST_HOLD: begin
				// Data and selects stay put past the rising edge for the hold time.
				if (cnt_done) begin
					nxt_pins.chip_select_n     = 1'b1;
					nxt_pins.transfer_select_n = (cmd_ff == DBLC_CMD_WRITE) ? 1'b0 : 1'b1;
					nxt_done  = 1'b1;
					nxt_state = DBLC_ST_IDLE;
				end
			end
			default: begin
				nxt_state = DBLC_ST_IDLE;
			end
		endcase
	end

	// State and pin registers; reset leaves every strobe inactive.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			state_ff <= DBLC_ST_IDLE;
			cmd_ff   <= DBLC_CMD_LOAD;
			done_ff  <= 1'b0;
			frz_ff   <= 1'b0;
			pins_ff  <= '{input_latch_qualifier: 1'b1, chip_select_n: 1'b1,
				input_write_strobe_n: 1'b1, transfer_write_strobe_n: 1'b1,
				transfer_select_n: 1'b1, data_in_bits: `DBLC_DATA_RST};
		end else begin
			state_ff <= nxt_state;
			cmd_ff   <= nxt_cmd;
			done_ff  <= nxt_done;
			frz_ff   <= FREEZE_I;
			pins_ff  <= nxt_pins;
		end
	end

	// Pin outputs come straight from the registered group.
	assign INPUT_LATCH_QUALIFIER_O   = pins_ff.input_latch_qualifier;
	assign CHIP_SELECT_N_O           = pins_ff.chip_select_n;
	assign INPUT_WRITE_STROBE_N_O    = pins_ff.input_write_strobe_n;
	assign TRANSFER_WRITE_STROBE_N_O = pins_ff.transfer_write_strobe_n;
	assign TRANSFER_SELECT_N_O       = pins_ff.transfer_select_n;
	assign DATA_IN_BITS_O            = pins_ff.data_in_bits;
	assign DONE_O                    = done_ff;
endmodule // dblc_host

// ===== test/dblc_host_props.sv
// Checker for strobe timing and sequencing of the latch controller.
`timescale 1ns/1ns
`include "dblc_defs.svh"
module dblc_host_props
	import dblc_pkg::*;
#(
	// Taken from the shared constants, not from the design, so a wrong
	// design figure cannot hide behind a matching checker figure.
	parameter int STROBE_CY = `DBLC_STROBE_CYC
) (
	input wire logic       CLK_SYS_I,
	input wire logic       RST_N_I,
	input wire logic       REQ_VALID_I,
	input wire dblc_cmd_t  REQ_CMD_I,
	input wire logic       FREEZE_I,
	input wire logic       REQ_READY_O,
	input wire logic       DONE_O,
	input wire logic       INPUT_LATCH_QUALIFIER_O,
	input wire logic       CHIP_SELECT_N_O,
	input wire logic       INPUT_WRITE_STROBE_N_O,
	input wire logic       TRANSFER_WRITE_STROBE_N_O,
	input wire logic       TRANSFER_SELECT_N_O,
	input wire logic [7:0] DATA_IN_BITS_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);
	logic [7:0] low_cnt_ff;  // Cycles the input strobe has been low.
	logic [7:0] nxt_low_cnt; // Saturates, so flow mode cannot wrap it.
	// Count the low time; clear on reset or while the strobe is high.
	always_comb begin
		nxt_low_cnt = low_cnt_ff + 8'h01;
		if (!RST_N_I || INPUT_WRITE_STROBE_N_O) begin
			nxt_low_cnt = 8'h00;
		end else if (low_cnt_ff == 8'hff) begin
			nxt_low_cnt = low_cnt_ff;
		end
	end
	// Register only.
	always_ff @(posedge CLK_SYS_I) begin
		low_cnt_ff <= nxt_low_cnt;
	end
	// Leaving flow-through also raises the strobe, but that is no timed write.
	chk_strobe_width: assert property (
		$rose(INPUT_WRITE_STROBE_N_O) && !$past(REQ_READY_O) |-> low_cnt_ff >= STROBE_CY)
		else $error("Input strobe shorter than minimum");
	chk_data_hold: assert property (
		$rose(INPUT_WRITE_STROBE_N_O) && !$past(REQ_READY_O)
		|-> $stable(DATA_IN_BITS_O) ##1 $stable(DATA_IN_BITS_O))
		else $error("Data moved around strobe rise");
	chk_done_after: assert property (
		$rose(INPUT_WRITE_STROBE_N_O) && !$past(REQ_READY_O) |=> DONE_O && CHIP_SELECT_N_O)
		else $error("Done not one cycle after strobe rise");
	chk_busy_refuse: assert property (
		REQ_VALID_I && REQ_READY_O && REQ_CMD_I != DBLC_CMD_FLOW |=> !REQ_READY_O)
		else $error("Ready stayed high during transfer");
	chk_freeze_path: assert property (
		INPUT_LATCH_QUALIFIER_O == !$past(FREEZE_I, 2))
		else $error("Qualifier does not follow freeze");
	chk_select_gates: assert property (
		!INPUT_WRITE_STROBE_N_O |-> !CHIP_SELECT_N_O)
		else $error("Input strobe without select");
	chk_flow_lines: assert property (
		REQ_VALID_I && REQ_READY_O && REQ_CMD_I == DBLC_CMD_FLOW |=> DONE_O
		&& !CHIP_SELECT_N_O && !INPUT_WRITE_STROBE_N_O && !TRANSFER_WRITE_STROBE_N_O
		&& !TRANSFER_SELECT_N_O)
		else $error("Flow lines not all low");
	chk_load_holds: assert property (
		REQ_VALID_I && REQ_READY_O && REQ_CMD_I == DBLC_CMD_LOAD
		|-> ##2 TRANSFER_WRITE_STROBE_N_O && TRANSFER_SELECT_N_O)
		else $error("Converter open during load");
endmodule // dblc_host_props
bind dblc_host dblc_host_props u_props (.CLK_SYS_I, .RST_N_I,
	.REQ_VALID_I, .REQ_CMD_I, .FREEZE_I, .REQ_READY_O, .DONE_O, .INPUT_LATCH_QUALIFIER_O,
	.CHIP_SELECT_N_O, .INPUT_WRITE_STROBE_N_O, .TRANSFER_WRITE_STROBE_N_O,
	.TRANSFER_SELECT_N_O, .DATA_IN_BITS_O);

// ===== test/dblc_conv_model.sv
// Behavioural model of the converter's two cascaded data latches.
`timescale 1ns/1ns
module dblc_conv_model
	import dblc_pkg::*;
(
	input  wire dblc_pins_t pins_i,
	output logic [7:0]      in_reg_o,
	output logic [7:0]      current_out_true_o,
	output logic [7:0]      current_out_complement_o
);
	logic [7:0] dac_reg; // Converter register feeding the ladder.
	// Input latch is open only while qualified and written; it keeps the
	// value present when the strobe rises.
	always_latch begin
		if (pins_i.input_latch_qualifier && !pins_i.chip_select_n
			&& !pins_i.input_write_strobe_n) begin
			in_reg_o = pins_i.data_in_bits;
		end
	end
	// Either line high holds the converter; both low make it follow.
	always_latch begin
		if (!pins_i.transfer_write_strobe_n && !pins_i.transfer_select_n) begin
			dac_reg = in_reg_o;
		end
	end
	assign current_out_true_o       = dac_reg;
	assign current_out_complement_o = 8'hff - dac_reg;
endmodule // dblc_conv_model

// ===== test/dblc_host_tb.sv
// Self-checking bench of the latch controller against a converter model.
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module dblc_host_tb
	import dblc_pkg::*;
;
	logic       clk = 1'b0;
	logic       rst_n, valid, freeze, ready, done;
	dblc_cmd_t  cmd;
	logic [7:0] data, in_reg, code, comp;
	dblc_pins_t pins; // Lines toward the converter.
	int         n_errors = 0;
	int         compares = 0;
	// Documented strobe and hold figures; the whole run stays a few hundred cycles.
	dblc_host dut (.CLK_SYS_I(clk), .RST_N_I(rst_n),
		.REQ_VALID_I(valid), .REQ_CMD_I(cmd), .REQ_DATA_I(data), .FREEZE_I(freeze),
		.REQ_READY_O(ready), .DONE_O(done),
		.INPUT_LATCH_QUALIFIER_O(pins.input_latch_qualifier),
		.CHIP_SELECT_N_O(pins.chip_select_n), .INPUT_WRITE_STROBE_N_O(pins.input_write_strobe_n),
		.TRANSFER_WRITE_STROBE_N_O(pins.transfer_write_strobe_n),
		.TRANSFER_SELECT_N_O(pins.transfer_select_n), .DATA_IN_BITS_O(pins.data_in_bits));
	dblc_conv_model u_conv (.pins_i(pins), .in_reg_o(in_reg), .current_out_true_o(code),
		.current_out_complement_o(comp));
	always #25 clk = ~clk;
	// One request, then a bounded wait for its completion pulse.
	task automatic req(input dblc_cmd_t c, input logic [7:0] d);
		int n;
		@(negedge clk);
		valid = 1'b1;
		cmd = c;
		data = d;
		@(negedge clk);
		valid = 1'b0;
		`CHK(ready, (c == DBLC_CMD_FLOW))
		n = 0;
		while (done !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		`CHK(done, 1'b1)
	endtask
	task automatic t_double();
		req(DBLC_CMD_LOAD, 8'ha5);
		`CHK(in_reg, 8'ha5)
		req(DBLC_CMD_TRANSFER_SELECT_N, 8'h00);
		`CHK(code, 8'ha5)
		req(DBLC_CMD_LOAD, 8'h3c);
		`CHK(code, 8'ha5)
		req(DBLC_CMD_TRANSFER_SELECT_N, 8'h00);
		`CHK(code, 8'h3c)
		$display("Test double-buffered finished");
	endtask
	task automatic t_freeze();
		freeze = 1'b1;
		repeat (3) @(negedge clk);
		req(DBLC_CMD_LOAD, 8'h77);
		`CHK(in_reg, 8'h3c)
		freeze = 1'b0;
		repeat (3) @(negedge clk);
		`CHK(pins.input_latch_qualifier, 1'b1)
		req(DBLC_CMD_TRANSFER_SELECT_N, 8'h00);
		`CHK(code, 8'h3c)
		$display("Test freeze finished");
	endtask
	task automatic t_single_flow();
		req(DBLC_CMD_WRITE, 8'h81);
		`CHK(code, 8'h81)
		`CHK(comp, 8'h7e)
		req(DBLC_CMD_FLOW, 8'h01);
		`CHK(code, 8'h01)
		req(DBLC_CMD_FLOW, 8'h80);
		`CHK(code, 8'h80)
		req(DBLC_CMD_LOAD, 8'h42);
		req(DBLC_CMD_TRANSFER_SELECT_N, 8'h00);
		`CHK(code, 8'h42)
		$display("Test single and flow finished");
	endtask
	// A request held up while the controller is busy must be ignored.
	task automatic t_refuse();
		int n;
		@(negedge clk);
		valid = 1'b1;
		cmd = DBLC_CMD_LOAD;
		data = 8'h11;
		@(negedge clk);
		cmd = DBLC_CMD_TRANSFER_SELECT_N;
		data = 8'h99;
		`CHK(ready, 1'b0)
		repeat (4) @(negedge clk);
		valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		`CHK(done, 1'b1)
		`CHK(in_reg, 8'h11)
		`CHK(pins.data_in_bits, 8'h11)
		`CHK(code, 8'h42)
		$display("Test busy refusal finished");
	endtask
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Whole run is a few hundred cycles; this limit cuts a hang.
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		conclude();
	end
	initial begin
		rst_n = 1'b0;
		valid = 1'b0;
		freeze = 1'b0;
		cmd = DBLC_CMD_LOAD;
		data = 8'h00;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		t_double();
		t_freeze();
		t_single_flow();
		t_refuse();
		conclude();
	end
endmodule // dblc_host_tb
